//--- core/axis_homing_sequencer.sv
// homing sequencer for one axis, modes 3 to 10
`timescale 1ns/100ps
`default_nettype none

module axis_homing_sequencer
	import homing_pkg::*;
#(
	parameter int POS_W = POS_W_DEF
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic homing_request,
	input wire logic [3:0] home_mode,
	input wire logic home_sw,
	input wire logic pos_limit,
	input wire logic index_pulse,
	input wire logic [POS_W-1:0] position,
	output var axis_cmd_t axis_cmd,
	output logic [POS_W-1:0] home_position,
	output logic home_done,
	output logic busy,
	output logic mode_error
);

	// refuse widths the capture register cannot hold
	if (POS_W < 1) begin : g_bad_width
		$error("POS_W must be at least 1");
	end

	home_state_t state_reg, state_next;
	axis_cmd_t cmd_reg, cmd_next;
	logic [3:0] mode_reg;
	logic req_prev_reg;
	logic idx_prev_reg;
	logic [POS_W-1:0] home_pos_reg;
	logic done_reg;
	logic busy_reg;
	logic bad_mode_reg;
	logic latch;

	// edge detection and request decode
	wire logic req_rise = homing_request && !req_prev_reg;
	wire logic idx_rise = index_pulse && !idx_prev_reg;
	wire logic idle = (state_reg == ST_IDLE);
	wire logic start_ok = idle && req_rise && mode_valid(home_mode);
	wire logic start_bad = idle && req_rise && !mode_valid(home_mode);
	wire logic limit_hit = pos_limit && cmd_reg.dir_pos && limit_mode(mode_reg);

	// sequencer next state and drive command
	always_comb begin
		state_next = state_reg;
		cmd_next = cmd_reg;
		latch = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				if (start_ok) begin
					cmd_next.move = 1'b1;
					if (home_sw) begin
						// switch on at start: slow run toward its off edge
						cmd_next.slow = SPEED_SLOW;
						cmd_next.dir_pos = on_start_pos(home_mode);
						state_next = ST_WAIT_OFF;
					end else begin
						// switch off at start: fast seek
						cmd_next.slow = SPEED_FAST;
						cmd_next.dir_pos = off_start_pos(home_mode);
						state_next = ST_FAST;
					end
				end
			end
			ST_FAST: begin
				if (home_sw) begin
					cmd_next.slow = SPEED_SLOW;
					if (turn_at_on(mode_reg)) begin
						cmd_next.dir_pos = !cmd_reg.dir_pos;
						state_next = ST_WAIT_OFF;
					end else if (arm_at_on(mode_reg)) begin
						state_next = ST_ARMED;
					end else begin
						state_next = ST_WAIT_OFF;
					end
				end else if (limit_hit) begin
					// limit reached with switch off: back off fast
					cmd_next.dir_pos = DIR_NEG;
					cmd_next.slow = SPEED_FAST;
					state_next = ST_LIMIT;
				end
			end
			ST_LIMIT: begin
				if (home_sw) begin
					if (mode_reg == MODE_8) begin
						state_next = ST_PASS;
					end else if (mode_reg == MODE_9) begin
						cmd_next.slow = SPEED_SLOW;
						state_next = ST_ARMED;
					end else if (mode_reg == MODE_10) begin
						cmd_next.slow = SPEED_SLOW;
						cmd_next.dir_pos = DIR_POS;
						state_next = ST_WAIT_OFF;
					end else begin
						cmd_next.slow = SPEED_SLOW;
						state_next = ST_WAIT_OFF;
					end
				end
			end
			ST_PASS: begin
				// switch passed, come back fast and seek it again
				if (!home_sw) begin
					cmd_next.dir_pos = DIR_POS;
					state_next = ST_FAST;
				end
			end
			ST_WAIT_OFF: begin
				if (!home_sw) begin
					if (turn_at_off(mode_reg)) begin
						cmd_next.dir_pos = !cmd_reg.dir_pos;
					end
					state_next = ST_ARMED;
				end
			end
			ST_ARMED: begin
				if (idx_rise) begin
					cmd_next.move = 1'b0;
					latch = 1'b1;
					state_next = ST_IDLE;
				end
			end
			default: begin
				cmd_next = CMD_RST;
				state_next = ST_IDLE;
			end
		endcase
	end

	// state, command and edge history
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= ST_IDLE;
			cmd_reg <= CMD_RST;
			req_prev_reg <= 1'b0;
			idx_prev_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else if (clk_en) begin
			state_reg <= state_next;
			cmd_reg <= cmd_next;
			req_prev_reg <= homing_request;
			idx_prev_reg <= index_pulse;
			busy_reg <= (state_next != ST_IDLE);
		end
	end

	// mode capture, home latch and status flags
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mode_reg <= MODE_RST;
			home_pos_reg <= '0;
			done_reg <= 1'b0;
			bad_mode_reg <= 1'b0;
		end else if (clk_en) begin
			if (start_ok) begin
				mode_reg <= home_mode;
			end
			if (latch) begin
				home_pos_reg <= position;
			end
			done_reg <= latch || (done_reg && !start_ok);
			bad_mode_reg <= start_bad || (bad_mode_reg && !start_ok);
		end
	end

	// outputs straight from registers
	assign axis_cmd = cmd_reg;
	assign home_position = home_pos_reg;
	assign home_done = done_reg;
	assign busy = busy_reg;
	assign mode_error = bad_mode_reg;

	// a valid request starts motion and marks busy
	a_request_starts: assert property (@(posedge mclk) disable iff (!rst_b)
		clk_en && start_ok |=> cmd_reg.move && busy_reg && !done_reg)
		else $error("homing request did not start motion");

	// no motion without a prior accepted request
	a_no_spurious_move: assert property (@(posedge mclk) disable iff (!rst_b)
		!$past(cmd_reg.move) && cmd_reg.move |-> $past(start_ok) && $past(clk_en))
		else $error("axis moved without a homing request");

	// switch level at start picks speed
	a_start_speed: assert property (@(posedge mclk) disable iff (!rst_b)
		clk_en && start_ok |=> cmd_reg.slow == $past(home_sw))
		else $error("start speed does not follow home switch level");

	// modes 3 and 7 starting on move negative
	a_on_start_neg: assert property (@(posedge mclk) disable iff (!rst_b)
		clk_en && start_ok && home_sw && (home_mode == MODE_3 || home_mode == MODE_7)
		|=> !cmd_reg.dir_pos && cmd_reg.slow)
		else $error("mode 3 or 7 with switch on did not run negative slow");

	// modes 5 and 6 starting off seek negative
	a_off_start_neg: assert property (@(posedge mclk) disable iff (!rst_b)
		clk_en && start_ok && !home_sw && (home_mode == MODE_5 || home_mode == MODE_6)
		|=> !cmd_reg.dir_pos && !cmd_reg.slow)
		else $error("mode 5 or 6 with switch off did not seek negative fast");

	// reversal at switch on for modes 3, 5, 7
	a_turn_on_switch: assert property (@(posedge mclk) disable iff (!rst_b)
		clk_en && state_reg == ST_FAST && home_sw && turn_at_on(mode_reg)
		|=> cmd_reg.slow && (cmd_reg.dir_pos != $past(cmd_reg.dir_pos)))
		else $error("no slow reversal when home switch came on");

	// positive limit sends the axis back fast
	a_limit_reverse: assert property (@(posedge mclk) disable iff (!rst_b)
		clk_en && state_reg == ST_FAST && !home_sw && limit_hit
		|=> !cmd_reg.dir_pos && !cmd_reg.slow && state_reg == ST_LIMIT)
		else $error("positive limit did not reverse the axis at first speed");

	// armed run is always slow and moving
	a_armed_slow: assert property (@(posedge mclk) disable iff (!rst_b)
		state_reg == ST_ARMED |-> cmd_reg.slow && cmd_reg.move)
		else $error("index armed while not moving at second speed");

	// index edge stops axis and captures position
	a_index_latch: assert property (@(posedge mclk) disable iff (!rst_b)
		clk_en && state_reg == ST_ARMED && idx_rise
		|=> !cmd_reg.move && done_reg && home_pos_reg == $past(position))
		else $error("index edge did not stop and latch home");

	// index outside the armed state never latches
	a_index_ignored: assert property (@(posedge mclk) disable iff (!rst_b)
		clk_en && state_reg != ST_ARMED && !start_ok |=> $stable(home_pos_reg))
		else $error("home position changed before index was armed");

	// switch off in a reversing mode turns the slow run and arms
	a_off_turns: assert property (@(posedge mclk) disable iff (!rst_b)
		clk_en && state_reg == ST_WAIT_OFF && !home_sw
		&& (mode_reg == MODE_4 || mode_reg == MODE_6
		|| mode_reg == MODE_8 || mode_reg == MODE_9)
		|=> cmd_reg.slow && (cmd_reg.dir_pos != $past(cmd_reg.dir_pos)) && state_reg == ST_ARMED)
		else $error("no slow reversal when home switch went off");

	// switch off in a straight mode arms without turning
	a_off_keeps: assert property (@(posedge mclk) disable iff (!rst_b)
		clk_en && state_reg == ST_WAIT_OFF && !home_sw
		&& (mode_reg == MODE_3 || mode_reg == MODE_5
		|| mode_reg == MODE_7 || mode_reg == MODE_10)
		|=> cmd_reg.slow && (cmd_reg.dir_pos == $past(cmd_reg.dir_pos)) && state_reg == ST_ARMED)
		else $error("direction changed or index not armed at switch off");

	// switch on arms at once in modes 4, 6, 8
	a_on_arms: assert property (@(posedge mclk) disable iff (!rst_b)
		clk_en && state_reg == ST_FAST && home_sw
		&& (mode_reg == MODE_4 || mode_reg == MODE_6 || mode_reg == MODE_8)
		|=> cmd_reg.slow && (cmd_reg.dir_pos == $past(cmd_reg.dir_pos)) && state_reg == ST_ARMED)
		else $error("switch on did not slow down and arm the index");

	// switch on slows without turning in modes 9, 10
	a_fast_slows: assert property (@(posedge mclk) disable iff (!rst_b)
		clk_en && state_reg == ST_FAST && home_sw && (mode_reg == MODE_9 || mode_reg == MODE_10)
		|=> cmd_reg.slow && (cmd_reg.dir_pos == $past(cmd_reg.dir_pos))
		&& state_reg == ST_WAIT_OFF)
		else $error("switch on did not slow the seek");

	// mode 8 backing off from the limit passes the switch fast
	a_limit_pass: assert property (@(posedge mclk) disable iff (!rst_b)
		clk_en && state_reg == ST_LIMIT && home_sw && mode_reg == MODE_8
		|=> state_reg == ST_PASS && !cmd_reg.slow && !cmd_reg.dir_pos)
		else $error("mode 8 did not pass the switch at first speed");

	// switch passed: come back positive fast
	a_pass_return: assert property (@(posedge mclk) disable iff (!rst_b)
		clk_en && state_reg == ST_PASS && !home_sw
		|=> state_reg == ST_FAST && cmd_reg.dir_pos && !cmd_reg.slow)
		else $error("no fast positive return after passing the switch");

	// modes 7, 9 keep backing off slowly on the switch
	a_limit_keep: assert property (@(posedge mclk) disable iff (!rst_b)
		clk_en && state_reg == ST_LIMIT && home_sw && (mode_reg == MODE_7 || mode_reg == MODE_9)
		|=> cmd_reg.slow && !cmd_reg.dir_pos && cmd_reg.move)
		else $error("limit run did not slow down negative on the switch");

	// mode 10 turns positive slow on the switch after the limit
	a_limit_turn: assert property (@(posedge mclk) disable iff (!rst_b)
		clk_en && state_reg == ST_LIMIT && home_sw && mode_reg == MODE_10
		|=> cmd_reg.slow && cmd_reg.dir_pos && state_reg == ST_WAIT_OFF)
		else $error("mode 10 did not turn slow at the switch");

	// modes 5, 6, 9, 10 starting on run positive slow
	a_on_start_pos: assert property (@(posedge mclk) disable iff (!rst_b)
		clk_en && start_ok && home_sw && (home_mode == MODE_5 || home_mode == MODE_6
		|| home_mode == MODE_9 || home_mode == MODE_10)
		|=> cmd_reg.dir_pos && cmd_reg.slow)
		else $error("start on the switch did not run positive slow");

	// modes 3, 4, 7 to 10 starting off seek positive fast
	a_off_start_pos: assert property (@(posedge mclk) disable iff (!rst_b)
		clk_en && start_ok && !home_sw && (home_mode == MODE_3 || home_mode == MODE_4
		|| home_mode == MODE_7 || home_mode == MODE_8 || home_mode == MODE_9
		|| home_mode == MODE_10)
		|=> cmd_reg.dir_pos && !cmd_reg.slow)
		else $error("start off the switch did not seek positive fast");

	// refused mode flags an error and leaves the axis still
	a_bad_mode: assert property (@(posedge mclk) disable iff (!rst_b)
		clk_en && start_bad |=> mode_error && !busy && !cmd_reg.move)
		else $error("refused mode did not flag or started motion");

	// low clock enable holds state, command, home position and done flag
	a_enable_freeze: assert property (@(posedge mclk) disable iff (!rst_b)
		!clk_en |=> $stable(state_reg) && $stable(cmd_reg) && $stable(home_pos_reg)
		&& $stable(done_reg))
		else $error("state changed while clock enable was low");

endmodule // axis_homing_sequencer

`default_nettype wire

//--- core/homing_pkg.sv
// package: homing modes, states, command carrier and decode helpers
package homing_pkg;

	// supported homing mode codes
	localparam logic [3:0] MODE_3 = 4'h3;
	localparam logic [3:0] MODE_4 = 4'h4;
	localparam logic [3:0] MODE_5 = 4'h5;
	localparam logic [3:0] MODE_6 = 4'h6;
	localparam logic [3:0] MODE_7 = 4'h7;
	localparam logic [3:0] MODE_8 = 4'h8;
	localparam logic [3:0] MODE_9 = 4'h9;
	localparam logic [3:0] MODE_10 = 4'ha;

	// default widths and reset values
	localparam int POS_W_DEF = 32;
	localparam logic [3:0] MODE_RST = 4'h0;
	localparam logic DIR_POS = 1'b1;
	localparam logic DIR_NEG = 1'b0;
	localparam logic SPEED_FAST = 1'b0;
	localparam logic SPEED_SLOW = 1'b1;

	// sequencer states, one-hot
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_FAST = 6'h02,
		ST_LIMIT = 6'h04,
		ST_PASS = 6'h08,
		ST_WAIT_OFF = 6'h10,
		ST_ARMED = 6'h20
	} home_state_t;

	// command to the axis drive
	typedef struct packed {
		logic move;
		logic dir_pos;
		logic slow;
	} axis_cmd_t;

	localparam axis_cmd_t CMD_RST = '{move: 1'b0, dir_pos: 1'b0, slow: 1'b0};

	// mode lies in the handled range
	function automatic logic mode_valid(input logic [3:0] m);
		return (m >= MODE_3) && (m <= MODE_10);
	endfunction

	// modes that watch the positive limit switch
	function automatic logic limit_mode(input logic [3:0] m);
		return (m >= MODE_7) && (m <= MODE_10);
	endfunction

	// reverse when switch comes on during the fast seek
	function automatic logic turn_at_on(input logic [3:0] m);
		return (m == MODE_3) || (m == MODE_5) || (m == MODE_7);
	endfunction

	// arm index directly when switch comes on during the fast seek
	function automatic logic arm_at_on(input logic [3:0] m);
		return (m == MODE_4) || (m == MODE_6) || (m == MODE_8);
	endfunction

	// reverse when switch goes off during the slow run
	function automatic logic turn_at_off(input logic [3:0] m);
		return (m == MODE_4) || (m == MODE_6) || (m == MODE_8) || (m == MODE_9);
	endfunction

	// start direction when the switch is already on
	function automatic logic on_start_pos(input logic [3:0] m);
		return (m == MODE_5) || (m == MODE_6) || (m == MODE_9) || (m == MODE_10);
	endfunction

	// start direction when the switch is off
	function automatic logic off_start_pos(input logic [3:0] m);
		return !((m == MODE_5) || (m == MODE_6));
	endfunction

endpackage

//--- sim/axis_drive_model.sv
// axis drive model: turns the motion command into a position count
`timescale 1ns/100ps
`default_nettype none

module axis_drive_model
	import homing_pkg::*;
#(
	parameter int POS_W = POS_W_DEF,
	parameter int FAST_STEP = 8
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire axis_cmd_t axis_cmd,
	output logic [POS_W-1:0] position
);
	// step size follows speed phase
	logic [POS_W-1:0] step;
	assign step = axis_cmd.slow ? POS_W'(1) : POS_W'(FAST_STEP);

	// position integrator, stands still when not moving
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			position <= POS_W'(32'h1000);
		end else if (axis_cmd.move) begin
			position <= axis_cmd.dir_pos ? position + step : position - step;
		end
	end
endmodule // axis_drive_model

`default_nettype wire

//--- sim/tb.sv
// testbench: table-driven homing runs against the drive model
`timescale 1ns/100ps
`default_nettype none

module tb
	import homing_pkg::*;
;
	logic mclk = 1'b0, rst_b = 1'b0, homing_request = 1'b0;
	logic home_sw = 1'b0, pos_limit = 1'b0, index_pulse = 1'b0;
	logic clk_en = 1'b1;
	logic [3:0] home_mode = 4'h3;
	logic [31:0] position, home_position, pos_exp;
	axis_cmd_t axis_cmd;
	logic home_done, busy, mode_error;
	int err_count = 0, comparisons = 0;
	// mode, start switch, start cmd, then event and cmd pairs
	// events: N on, F off, L limit, X ignored index, R request while busy, I index
	string on_s[$] = '{"315X5R5F5I1", "415X5F7I3", "517X7F7I3", "617X7F5I1",
		"715X5F5I1", "815X5F7I3", "917X7F5I1", "a17X7F7I3"};
	string off_s[$] = '{"306X6N5F5I1", "406N7I3", "504N7F7I3", "604N5I1",
		"706N5F5I1", "806N7I3", "906N7F5I1", "a06N7F7I3"};
	string lim_s[$] = '{"706L4N5F5I1", "806L4N4F6N7I3", "906L4N5I1", "a06L4N7F7I3"};

	always #20 mclk = ~mclk;

	axis_homing_sequencer DUT (.mclk(mclk), .rst_b(rst_b), .clk_en(clk_en),
		.homing_request(homing_request), .home_mode(home_mode), .home_sw(home_sw),
		.pos_limit(pos_limit), .index_pulse(index_pulse), .position(position),
		.axis_cmd(axis_cmd), .home_position(home_position), .home_done(home_done),
		.busy(busy), .mode_error(mode_error));

	axis_drive_model drive (.mclk(mclk), .rst_b(rst_b), .axis_cmd(axis_cmd),
		.position(position));

	// expectation decoders for the table characters
	function automatic axis_cmd_t cmd_of(input byte c);
		return axis_cmd_t'(c[2:0]);
	endfunction

	function automatic logic [3:0] mode_of(input byte c);
		return (c >= "a") ? 4'(c - 8'h57) : c[3:0];
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic chk_cmd(input axis_cmd_t exp, input string what);
		comparisons++;
		if (axis_cmd !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: %s cmd %b exp %b", $time, what, axis_cmd, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string what);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: %s is %b", $time, what, got);
		end
	endtask

	task automatic chk_pos(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: home position %h exp %h", $time, got, exp);
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// one homing run following a table string
	task automatic run(input string s);
		tick(1);
		home_mode <= mode_of(s[0]);
		home_sw <= (s[1] == "1");
		homing_request <= 1'b1;
		tick(2);
		#1;
		chk_cmd(cmd_of(s[2]), s);
		chk_bit(busy, 1'b1, "busy");
		chk_bit(home_done | mode_error, 1'b0, "stale flags");
		tick(1);
		homing_request <= 1'b0;
		for (int i = 3; i < s.len(); i += 2) begin
			tick($urandom_range(6, 1));
			case (s[i])
				"N": home_sw <= 1'b1;
				"F": home_sw <= 1'b0;
				"L": pos_limit <= 1'b1;
				"R": homing_request <= 1'b1;
				default: index_pulse <= 1'b1;
			endcase
			tick(1);
			pos_exp = position;
			index_pulse <= 1'b0;
			pos_limit <= 1'b0;
			homing_request <= 1'b0;
			tick(1);
			#1;
			chk_cmd(cmd_of(s[i+1]), s);
		end
		chk_bit(home_done & !busy, 1'b1, "done");
		chk_pos(home_position, pos_exp);
	endtask

	task automatic run_all(input string q[$]);
		foreach (q[k]) run(q[k]);
	endtask

	initial begin
		void'($urandom(32'h210d));
		tick(8);
		rst_b <= 1'b1;
		#1;
		chk_cmd(CMD_RST, "reset");
		chk_bit(busy | home_done | mode_error, 1'b0, "reset flags");
		chk_pos(home_position, 32'h0);
		run_all(on_s);
		run_all(off_s);
		run_all(lim_s);
		for (int k = 0; k < 3; k++) begin
			tick(1);
			home_mode <= (k == 0) ? 4'h2 : 4'(11 + $urandom_range(4));
			homing_request <= 1'b1;
			tick(2);
			#1;
			chk_bit(mode_error & !busy, 1'b1, "refused mode");
			// refusal keeps the stopped command of the last limit run
			chk_cmd(cmd_of("3"), "refused");
			tick(1);
			homing_request <= 1'b0;
		end
		run(off_s[0]);
		// clock enable low freezes start and switch handling
		tick(1);
		clk_en <= 1'b0;
		home_mode <= MODE_4;
		homing_request <= 1'b1;
		tick(3);
		#1;
		chk_bit(busy, 1'b0, "frozen request");
		tick(1);
		clk_en <= 1'b1;
		tick(2);
		#1;
		chk_cmd(cmd_of("6"), "thawed start");
		tick(1);
		clk_en <= 1'b0;
		homing_request <= 1'b0;
		home_sw <= 1'b1;
		tick(3);
		#1;
		chk_cmd(cmd_of("6"), "frozen switch");
		tick(1);
		clk_en <= 1'b1;
		tick(2);
		#1;
		chk_cmd(cmd_of("7"), "thawed switch");
		tick(1);
		home_sw <= 1'b0;
		index_pulse <= 1'b1;
		tick(1);
		pos_exp = position;
		index_pulse <= 1'b0;
		tick(1);
		#1;
		chk_cmd(cmd_of("3"), "thawed index");
		chk_pos(home_position, pos_exp);
		conclude();
	end

	// watchdog against a hung sequence
	initial begin
		tick(20000);
		err_count++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		conclude();
	end
endmodule // tb

`default_nettype wire
